// ---- src/fcer_defines.svh ----
// register offsets, bit positions, reset values and timing counts
`ifndef FCER_DEFINES_SVH
`define FCER_DEFINES_SVH

`define FCER_ADDR_W 8
`define FCER_ADDR_FEATURE 8'h10
`define FCER_DATA_W 32

`define FCER_BIT_RES15 15
`define FCER_BIT_ONE 14
`define FCER_BIT_POLL_DIS 12
`define FCER_BIT_AUTO_PAD 11
`define FCER_BIT_AUTO_STRIP 10
`define FCER_BIT_MISSED 9
`define FCER_BIT_MISSED_MASK 8
`define FCER_BIT_USER_CMD 7
`define FCER_BIT_USER_FLAG 6
`define FCER_BIT_RXCOL 5
`define FCER_BIT_RXCOL_MASK 4
`define FCER_BIT_TXSTART 3
`define FCER_BIT_TXSTART_MASK 2

`define FCER_RESET_VALUE 32'h0000_4114

`define FCER_MIN_FRAME 16'h0040
`define FCER_FCS_LEN 16'h0004
`define FCER_MIN_DATA 16'h002e
`define FCER_RX_HDR_LEN 16'h000e

`define FCER_CLK_NS 10
`define FCER_POLL_NS 20480
`define FCER_POLL_CYCLES (`FCER_POLL_NS / `FCER_CLK_NS)

`endif

// ---- src/fcer_pkg.sv ----
// types shared by the feature control and event register block
package fcer_pkg;

    typedef struct packed {
        logic missed_wrap;
        logic rxcol_wrap;
        logic tx_begin;
    } fcer_event_t;

    typedef struct packed {
        logic tx_poll_disable;
        logic tx_auto_pad;
        logic rx_auto_strip;
    } fcer_feature_t;

    typedef struct packed {
        logic tx_check_seq_disable;
        logic desc_add_check_seq;
        logic [15:0] tx_len;
        logic [15:0] rx_frame_len;
        logic [15:0] rx_type_len;
    } fcer_frame_t;

    typedef enum logic [1:0] {
        FCER_POLL_IDLE = 2'b01,
        FCER_POLL_REQ = 2'b10
    } fcer_poll_state_t;

endpackage

// ---- src/fcer_tx_poll.sv ----
// transmit descriptor poll scheduler
`include "fcer_defines.svh"
module fcer_tx_poll #(
    parameter int unsigned INTERVAL = `FCER_POLL_CYCLES
) (
    // clock and reset
    input logic clk_i,
    input logic arst_n_i,
    // control
    input logic tx_poll_disable_i,
    input logic transmitter_on_i,
    input logic tx_demand_i,
    input logic rx_done_i,
    // poll request pulse
    output logic tx_poll_o
);
    import fcer_pkg::*;

    logic [15:0] timer;
    logic timer_hit;
    logic pending;
    logic take;
    fcer_poll_state_t state;

    assign timer_hit = (timer == 16'(INTERVAL - 1));
    assign take = (state == FCER_POLL_IDLE) && pending && transmitter_on_i;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            timer <= 16'h0000;
        end else if (timer_hit || tx_poll_disable_i) begin
            timer <= 16'h0000;
        end else begin
            timer <= timer + 16'h0001;
        end
    end

    // a new request in the take cycle is kept, so none is lost
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            pending <= 1'b0;
        end else if (!transmitter_on_i) begin
            pending <= 1'b0;
        end else begin
            pending <= (pending && !take) || tx_demand_i || rx_done_i
                || (timer_hit && !tx_poll_disable_i);
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= FCER_POLL_IDLE;
        end else begin
            case (state)
                FCER_POLL_IDLE: state <= take ? FCER_POLL_REQ : FCER_POLL_IDLE;
                FCER_POLL_REQ: state <= FCER_POLL_IDLE;
                default: state <= FCER_POLL_IDLE;
            endcase
        end
    end

    assign tx_poll_o = (state == FCER_POLL_REQ);

    poll_needs_transmitter_on_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        tx_poll_o |-> $past(transmitter_on_i))
        else $error("poll issued while transmitter was off");

    demand_polls_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (tx_demand_i && transmitter_on_i) ##1 transmitter_on_i[*2] |-> ##[0:1] tx_poll_o)
        else $error("demand did not lead to a poll");

endmodule

// ---- src/fcer_frame_len.sv ----
// transmit pad and check sequence decision, receive strip length
`include "fcer_defines.svh"
module fcer_frame_len (
    // clock and reset
    input logic clk_i,
    input logic arst_n_i,
    // settings and frame facts
    input fcer_pkg::fcer_feature_t feat_i,
    input fcer_pkg::fcer_frame_t frame_i,
    // decisions
    output logic [15:0] tx_pad_len_o,
    output logic tx_append_fcs_o,
    output logic [15:0] rx_store_len_o
);
    import fcer_pkg::*;

    function automatic logic [15:0] sat_sub(input logic [15:0] a, input logic [15:0] b);
        sat_sub = (a > b) ? 16'(a - b) : 16'h0000;
    endfunction

    logic short_tx;
    logic pad_in_rx;

    assign short_tx = feat_i.tx_auto_pad
        && (frame_i.tx_len < sat_sub(`FCER_MIN_FRAME, `FCER_FCS_LEN));
    assign pad_in_rx = frame_i.rx_type_len < `FCER_MIN_DATA;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            tx_pad_len_o <= 16'h0000;
            tx_append_fcs_o <= 1'b0;
        end else begin
            // pad fills to 60 bytes, leaving out the 4-byte check sequence, which follows the pad
            tx_pad_len_o <= short_tx
                ? sat_sub(sat_sub(`FCER_MIN_FRAME, `FCER_FCS_LEN), frame_i.tx_len)
                : 16'h0000;
            tx_append_fcs_o <= short_tx
                || frame_i.desc_add_check_seq || !frame_i.tx_check_seq_disable;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_store_len_o <= 16'h0000;
        end else if (!feat_i.rx_auto_strip) begin
            rx_store_len_o <= frame_i.rx_frame_len;
        end else if (pad_in_rx) begin
            rx_store_len_o <= 16'(`FCER_RX_HDR_LEN + frame_i.rx_type_len);
        end else begin
            rx_store_len_o <= sat_sub(frame_i.rx_frame_len, `FCER_FCS_LEN);
        end
    end

    pad_to_min_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        short_tx |=> (tx_append_fcs_o
        && 16'(tx_pad_len_o + $past(frame_i.tx_len) + `FCER_FCS_LEN) == `FCER_MIN_FRAME))
        else $error("short frame not padded to minimum with check sequence");

endmodule

// ---- src/fcer_core.sv ----
// feature control and event register with poll and frame length helpers
//
// Summary of operation
// - writing one to an event bit clears it; read-back-write clears pending events
// - bit 14 always reads one; writes to it do nothing
// - poll disable bit 12 stops automatic polls; demand gives one manual poll
// - no poll while transmitter off; a poll follows receive activity
// - auto pad bit 11 extends short frames to 64 bytes with check sequence
// - auto pad on short frames overrides global and descriptor check settings
// - auto strip bit 10 removes pad and check sequence from received frames
// - missed counter wrap sets bit 9; interrupt if enabled and mask clear
// - missed overflow clears on write one, resets or stop
// - mask bit 8 blocks missed overflow; presets on resets, ignores stop
// - user command bit 7 requests interrupt while set and enabled
// - writing one to user flag clears command; resets and stop clear it
// - user flag bit 6 sets after the command; clears on write one, reset, stop
// - receive collision wrap sets bit 5; interrupt if enabled and mask clear
// - collision overflow clears on write one, resets or stop
// - mask bit 4 blocks collision overflow; presets on resets, ignores stop
// - frame start sets bit 3; interrupt via mask bit 2; clears on write one
// - mask bit 2 blocks transmit start; presets on resets, ignores stop
// - reserved bits read zero except bit 15, which reads back its last write; feature bits clear on resets, not on stop
// - global interrupt enable comes from the main control register
//
// Added by the designer: the plain strobed port and the placing of the registers.
`include "fcer_defines.svh"
module fcer_core #(
    parameter int unsigned POLL_INTERVAL = `FCER_POLL_CYCLES
) (
    // clock and reset
    input logic clk_i,
    input logic arst_n_i,
    // register port
    input logic [`FCER_ADDR_W-1:0] addr_i,
    input logic [`FCER_DATA_W-1:0] wdata_i,
    input logic wr_i,
    input logic rd_i,
    output logic [`FCER_DATA_W-1:0] rdata_o,
    // device control from elsewhere
    input logic soft_reset_i,
    input logic stop_cmd_i,
    input logic global_irq_enable_i,
    input logic transmitter_on_i,
    input logic tx_demand_i,
    input logic rx_done_i,
    input fcer_pkg::fcer_event_t event_i,
    input fcer_pkg::fcer_frame_t frame_i,
    // interrupt
    output logic combined_irq_flag_o,
    output logic inta_o,
    // features and datapath decisions
    output fcer_pkg::fcer_feature_t feat_o,
    output logic tx_poll_o,
    output logic [15:0] tx_pad_len_o,
    output logic tx_append_fcs_o,
    output logic [15:0] rx_store_len_o
);
    import fcer_pkg::*;

    logic sel;
    logic wr_hit;
    logic [`FCER_DATA_W-1:0] w1c;
    logic res15;
    logic tx_poll_disable;
    logic tx_auto_pad;
    logic rx_auto_strip;
    logic missed_count_overflow;
    logic missed_count_overflow_mask;
    logic user_irq_command;
    logic user_irq_flag;
    logic user_irq_set;
    logic rx_collision_overflow;
    logic rx_collision_overflow_mask;
    logic tx_start_flag;
    logic tx_start_mask;
    logic event_clear;
    logic next_combined;
    logic [`FCER_DATA_W-1:0] reg_view;

    assign sel = (addr_i == `FCER_ADDR_FEATURE);
    assign wr_hit = wr_i && sel;
    // write-one-to-clear strobes, per bit
    assign w1c = wr_hit ? wdata_i : '0;
    // soft reset and stop both wipe the event state
    assign event_clear = soft_reset_i || stop_cmd_i;

    // feature bits and bit 15: hard or soft reset or a write of zero clear them, stop does not
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            res15 <= 1'b0;
            tx_poll_disable <= 1'b0;
            tx_auto_pad <= 1'b0;
            rx_auto_strip <= 1'b0;
        end else if (soft_reset_i) begin
            res15 <= 1'b0;
            tx_poll_disable <= 1'b0;
            tx_auto_pad <= 1'b0;
            rx_auto_strip <= 1'b0;
        end else if (wr_hit) begin
            res15 <= wdata_i[`FCER_BIT_RES15];
            tx_poll_disable <= wdata_i[`FCER_BIT_POLL_DIS];
            tx_auto_pad <= wdata_i[`FCER_BIT_AUTO_PAD];
            rx_auto_strip <= wdata_i[`FCER_BIT_AUTO_STRIP];
        end
    end

    // masks preset to one on resets and ignore stop
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            missed_count_overflow_mask <= 1'b1;
            rx_collision_overflow_mask <= 1'b1;
            tx_start_mask <= 1'b1;
        end else if (soft_reset_i) begin
            missed_count_overflow_mask <= 1'b1;
            rx_collision_overflow_mask <= 1'b1;
            tx_start_mask <= 1'b1;
        end else if (wr_hit) begin
            missed_count_overflow_mask <= wdata_i[`FCER_BIT_MISSED_MASK];
            rx_collision_overflow_mask <= wdata_i[`FCER_BIT_RXCOL_MASK];
            tx_start_mask <= wdata_i[`FCER_BIT_TXSTART_MASK];
        end
    end

    // hardware event flags: an event beats a write-one clear, but stop or soft reset beats the event
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            missed_count_overflow <= 1'b0;
            rx_collision_overflow <= 1'b0;
            tx_start_flag <= 1'b0;
        end else if (event_clear) begin
            missed_count_overflow <= 1'b0;
            rx_collision_overflow <= 1'b0;
            tx_start_flag <= 1'b0;
        end else begin
            missed_count_overflow <= event_i.missed_wrap
                || (missed_count_overflow && !w1c[`FCER_BIT_MISSED]);
            rx_collision_overflow <= event_i.rxcol_wrap
                || (rx_collision_overflow && !w1c[`FCER_BIT_RXCOL]);
            tx_start_flag <= event_i.tx_begin
                || (tx_start_flag && !w1c[`FCER_BIT_TXSTART]);
        end
    end

    // command is set by a write of one and cleared through the user flag
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            user_irq_command <= 1'b0;
        end else if (event_clear) begin
            user_irq_command <= 1'b0;
        end else if (w1c[`FCER_BIT_USER_FLAG]) begin
            user_irq_command <= 1'b0;
        end else if (w1c[`FCER_BIT_USER_CMD]) begin
            user_irq_command <= 1'b1;
        end
    end

    // flag follows a fresh command by one cycle; the same write cannot
    // both raise the command and ack it, so the ack takes precedence there
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            user_irq_set <= 1'b0;
        end else begin
            user_irq_set <= w1c[`FCER_BIT_USER_CMD] && !w1c[`FCER_BIT_USER_FLAG]
                && !user_irq_command && !event_clear;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            user_irq_flag <= 1'b0;
        end else if (event_clear) begin
            user_irq_flag <= 1'b0;
        end else begin
            user_irq_flag <= user_irq_set
                || (user_irq_flag && !w1c[`FCER_BIT_USER_FLAG]);
        end
    end

    assign next_combined = (missed_count_overflow && !missed_count_overflow_mask)
        || (rx_collision_overflow && !rx_collision_overflow_mask)
        || (tx_start_flag && !tx_start_mask)
        || user_irq_flag || user_irq_command;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            combined_irq_flag_o <= 1'b0;
            inta_o <= 1'b0;
        end else begin
            combined_irq_flag_o <= next_combined;
            inta_o <= next_combined && global_irq_enable_i;
        end
    end

    always_comb begin
        reg_view = '0;
        reg_view[`FCER_BIT_RES15] = res15;
        reg_view[`FCER_BIT_ONE] = 1'b1;
        reg_view[`FCER_BIT_POLL_DIS] = tx_poll_disable;
        reg_view[`FCER_BIT_AUTO_PAD] = tx_auto_pad;
        reg_view[`FCER_BIT_AUTO_STRIP] = rx_auto_strip;
        reg_view[`FCER_BIT_MISSED] = missed_count_overflow;
        reg_view[`FCER_BIT_MISSED_MASK] = missed_count_overflow_mask;
        reg_view[`FCER_BIT_USER_CMD] = user_irq_command;
        reg_view[`FCER_BIT_USER_FLAG] = user_irq_flag;
        reg_view[`FCER_BIT_RXCOL] = rx_collision_overflow;
        reg_view[`FCER_BIT_RXCOL_MASK] = rx_collision_overflow_mask;
        reg_view[`FCER_BIT_TXSTART] = tx_start_flag;
        reg_view[`FCER_BIT_TXSTART_MASK] = tx_start_mask;
    end

    // read data stand for one cycle only; unmapped addresses read zero
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_o <= '0;
        end else if (rd_i && sel) begin
            rdata_o <= reg_view;
        end else begin
            rdata_o <= '0;
        end
    end

    assign feat_o.tx_poll_disable = tx_poll_disable;
    assign feat_o.tx_auto_pad = tx_auto_pad;
    assign feat_o.rx_auto_strip = rx_auto_strip;

    fcer_tx_poll #(
        .INTERVAL(POLL_INTERVAL)
    ) u_poll (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .tx_poll_disable_i(tx_poll_disable),
        .transmitter_on_i(transmitter_on_i),
        .tx_demand_i(tx_demand_i),
        .rx_done_i(rx_done_i),
        .tx_poll_o(tx_poll_o)
    );

    fcer_frame_len u_len (
        .clk_i(clk_i),
        .arst_n_i(arst_n_i),
        .feat_i(feat_o),
        .frame_i(frame_i),
        .tx_pad_len_o(tx_pad_len_o),
        .tx_append_fcs_o(tx_append_fcs_o),
        .rx_store_len_o(rx_store_len_o)
    );

    // checks on the register and interrupt behaviour
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    logic rd_q;
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_q <= 1'b0;
        end else begin
            rd_q <= rd_i && sel;
        end
    end

    bit_one_read_a: assert property (
        rd_q |-> rdata_o[`FCER_BIT_ONE] && rdata_o[31:16] == 16'h0000
        && rdata_o[13] == 1'b0 && rdata_o[1:0] == 2'b00)
        else $error("fixed or reserved bits read wrongly");

    write_one_clear_a: assert property (
        (wr_hit && wdata_i[`FCER_BIT_MISSED] && !event_i.missed_wrap)
        |=> !missed_count_overflow)
        else $error("missed overflow not cleared by write of one");

    write_zero_hold_a: assert property (
        (rx_collision_overflow && !w1c[`FCER_BIT_RXCOL] && !event_clear)
        |=> rx_collision_overflow)
        else $error("collision overflow lost without a clear");

    event_set_a: assert property (
        (event_i.missed_wrap && !event_clear) |=> missed_count_overflow)
        else $error("missed counter wrap did not set its flag");

    txstart_set_a: assert property (
        (event_i.tx_begin && !event_clear) |=> tx_start_flag ##1 (tx_start_flag
        || $past(w1c[`FCER_BIT_TXSTART]) || $past(event_clear)))
        else $error("transmit start flag not held");

    stop_clear_a: assert property (
        (stop_cmd_i && !soft_reset_i) |=> !missed_count_overflow && !user_irq_command
        && !user_irq_flag && $stable(tx_start_mask) && $stable(tx_auto_pad))
        else $error("stop handled wrongly");

    mask_preset_a: assert property (
        soft_reset_i |=> missed_count_overflow_mask && rx_collision_overflow_mask
        && tx_start_mask && !tx_poll_disable && !res15)
        else $error("soft reset did not preset masks");

    masked_quiet_a: assert property (
        (rx_collision_overflow && rx_collision_overflow_mask && !user_irq_flag
        && !user_irq_command && !missed_count_overflow && !tx_start_flag)
        |=> !combined_irq_flag_o)
        else $error("masked event reached combined flag");

    inta_gate_a: assert property (
        inta_o == ($past(next_combined) && $past(global_irq_enable_i)))
        else $error("interrupt line not gated by global enable");

    user_cmd_irq_a: assert property (
        (user_irq_command && global_irq_enable_i) |=> inta_o)
        else $error("user command did not raise interrupt");

    user_flag_follow_a: assert property (
        (w1c[`FCER_BIT_USER_CMD] && !user_irq_command && !w1c[`FCER_BIT_USER_FLAG]
        && !event_clear) ##1 !event_clear |=> user_irq_flag)
        else $error("user flag did not follow the command");

    user_ack_a: assert property (
        (w1c[`FCER_BIT_USER_FLAG] && !user_irq_set) |=> !user_irq_command && !user_irq_flag)
        else $error("user flag ack did not clear command");

    cover_user_irq_c: cover property (
        w1c[`FCER_BIT_USER_CMD] ##2 inta_o ##[1:20] w1c[`FCER_BIT_USER_FLAG]);

    cover_set_clear_c: cover property (
        event_i.rxcol_wrap && w1c[`FCER_BIT_RXCOL]);

    cover_poll_c: cover property (
        tx_poll_disable && tx_demand_i ##[1:4] tx_poll_o);

    cover_pad_c: cover property (
        tx_auto_pad && tx_append_fcs_o && tx_pad_len_o != 16'h0000);

endmodule

// ---- sim/fcer_core_tb.sv ----
// self-checking bench for the feature control and event register
module fcer_core_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import fcer_pkg::*;
    localparam int POLL = 16;
    localparam logic [7:0] A = 8'h10;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic soft_reset_i = 1'b0;
    logic stop_cmd_i = 1'b0;
    logic global_irq_enable_i = 1'b1;
    logic transmitter_on_i = 1'b0;
    logic tx_demand_i = 1'b0;
    logic rx_done_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [31:0] wdata_i = 32'h0;
    fcer_event_t event_i = '0;
    fcer_frame_t frame_i = '0;
    logic [31:0] rdata_o;
    logic combined_irq_flag_o, inta_o, tx_poll_o, tx_append_fcs_o;
    logic [15:0] tx_pad_len_o, rx_store_len_o;
    fcer_feature_t feat_o;
    logic [31:0] exp_q[$];
    logic [31:0] rnd = 32'hf25a70d8;
    logic rd_d = 1'b0;
    int err_total = 0, checks_done = 0, polls = 0, cycles = 0, p0;
    int fb[3] = '{9, 5, 3};
    int mb[3] = '{8, 4, 2};

    fcer_core #(.POLL_INTERVAL(POLL)) i_dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
        .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .soft_reset_i(soft_reset_i), .stop_cmd_i(stop_cmd_i),
        .global_irq_enable_i(global_irq_enable_i), .transmitter_on_i(transmitter_on_i),
        .tx_demand_i(tx_demand_i), .rx_done_i(rx_done_i), .event_i(event_i),
        .frame_i(frame_i), .combined_irq_flag_o(combined_irq_flag_o), .inta_o(inta_o),
        .feat_o(feat_o), .tx_poll_o(tx_poll_o), .tx_pad_len_o(tx_pad_len_o),
        .tx_append_fcs_o(tx_append_fcs_o), .rx_store_len_o(rx_store_len_o));

    initial begin
        forever #5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic summarize();
        $display("checks %0d errors %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", n, exp, seen);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask

    // expectation queued before the strobe; the monitor pops it
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk_i);
        rd_i <= 1'b0;
    endtask

    task automatic evt(input fcer_event_t e);
        @(posedge clk_i);
        event_i <= e;
        @(posedge clk_i);
        event_i <= '0;
    endtask

    // combined flag lags a register change by one cycle, inta by the same
    task automatic irq(input logic c, input logic i);
        cyc(2);
        #1;
        chk("combined", {31'h0, combined_irq_flag_o}, {31'h0, c});
        chk("inta", {31'h0, inta_o}, {31'h0, i});
    endtask

    task automatic pls(input int w);
        @(posedge clk_i);
        if (w == 0) tx_demand_i <= 1'b1;
        else rx_done_i <= 1'b1;
        @(posedge clk_i);
        tx_demand_i <= 1'b0;
        rx_done_i <= 1'b0;
        cyc(3);
        #1;
    endtask

    task automatic frm(input logic [49:0] f, input logic [15:0] pad, input logic fcs,
            input logic [15:0] st);
        @(posedge clk_i);
        frame_i <= f;
        cyc(2);
        #1;
        chk("pad", {16'h0, tx_pad_len_o}, {16'h0, pad});
        chk("fcs", {31'h0, tx_append_fcs_o}, {31'h0, fcs});
        chk("store", {16'h0, rx_store_len_o}, {16'h0, st});
    endtask

    always @(posedge clk_i) rd_d <= rd_i;

    always @(negedge clk_i) begin
        if (rd_d === 1'b1) chk("rdata", rdata_o, exp_q.pop_front());
    end

    // hang guard, generous against the few hundred cycles needed
    always @(posedge clk_i) begin
        cycles++;
        if (tx_poll_o === 1'b1) polls++;
        if (cycles == 6000) begin
            err_total++;
            summarize();
        end
    end

    initial begin
        cyc(4);
        #3;
        arst_n_i = 1'b1;
        rd(A, 32'h0000_4114);
        wr(A, 32'h0000_dffc);
        rd(A, 32'h0000_dd14);
        chk("feat", {29'h0, feat_o}, 32'h7);
        wr(A, 32'h0);
        rd(A, 32'h0000_4000);
        wr(8'h20, 32'hffff_ffff);
        rd(8'h20, 32'h0);
        rd(A, 32'h0000_4000);
        for (int i = 0; i < 8; i++) begin
            rnd = lfsr(rnd);
            wr(A, rnd & 32'h0000_df7c);
            rd(A, (rnd & 32'h0000_9d14) | 32'h0000_4000);
        end
        wr(A, 32'h0000_0114);
        for (int i = 0; i < 3; i++) begin
            evt(fcer_event_t'(3'h4 >> i));
            irq(1'b0, 1'b0);
            rd(A, 32'h0000_4114 | (32'h1 << fb[i]));
            wr(A, 32'h0000_0114 & ~(32'h1 << mb[i]));
            irq(1'b1, 1'b1);
            global_irq_enable_i <= 1'b0;
            irq(1'b1, 1'b0);
            global_irq_enable_i <= 1'b1;
            wr(A, (32'h0000_0114 & ~(32'h1 << mb[i])) | (32'h1 << fb[i]));
            irq(1'b0, 1'b0);
            wr(A, 32'h0000_0114);
        end
        wr(A, 32'h0000_9c00);
        evt(fcer_event_t'(3'h7));
        wr(A, 32'h0000_9c80);
        rd(A, 32'h0000_dee8);
        @(posedge clk_i);
        stop_cmd_i <= 1'b1;
        @(posedge clk_i);
        stop_cmd_i <= 1'b0;
        rd(A, 32'h0000_dc00);
        @(posedge clk_i);
        soft_reset_i <= 1'b1;
        @(posedge clk_i);
        soft_reset_i <= 1'b0;
        rd(A, 32'h0000_4114);
        wr(A, 32'h0000_0194);
        irq(1'b1, 1'b1);
        rd(A, 32'h0000_41d4);
        wr(A, 32'h0000_0154);
        rd(A, 32'h0000_4114);
        irq(1'b0, 1'b0);
        wr(A, 32'h0000_1114);
        transmitter_on_i <= 1'b1;
        p0 = polls;
        cyc(40);
        #1;
        chk("poll", polls - p0, 32'h0);
        pls(0);
        chk("poll", polls - p0, 32'h1);
        pls(1);
        chk("poll", polls - p0, 32'h2);
        transmitter_on_i <= 1'b0;
        pls(0);
        chk("poll", polls - p0, 32'h2);
        wr(A, 32'h0000_0114);
        transmitter_on_i <= 1'b1;
        p0 = polls;
        cyc(3 * POLL + 2);
        #1;
        chk("autopoll", 32'(polls - p0 >= 2), 32'h1);
        wr(A, 32'h0000_0d14);
        frm({1'b1, 1'b0, 16'h0014, 16'h003c, 16'h0014}, 16'h0028, 1'b1, 16'h0022);
        frm({1'b1, 1'b0, 16'h003c, 16'h0076, 16'h0064}, 16'h0000, 1'b0, 16'h0072);
        frm({1'b0, 1'b1, 16'h003b, 16'h0040, 16'h002e}, 16'h0001, 1'b1, 16'h003c);
        wr(A, 32'h0000_0114);
        frm({1'b1, 1'b0, 16'h0014, 16'h003c, 16'h0014}, 16'h0000, 1'b0, 16'h003c);
        summarize();
    end
endmodule
